// ### rcs_defines.vh
// Purpose: Shared constants for the reset cause and status logic.
// Assumes: 8-bit register data, byte-indexed register offsets.
// Notes: Definitions only; included by bare name.
`ifndef RCS_DEFINES_VH
`define RCS_DEFINES_VH

// Register offsets on the plain register port
`define RCS_OFS_RESET_CONTROL 4'h0
`define RCS_OFS_STACK_POINTER 4'h1
`define RCS_OFS_STACK_TOP_UPPER 4'h2
`define RCS_OFS_STACK_TOP_HIGH 4'h3
`define RCS_OFS_STACK_TOP_LOW 4'h4
`define RCS_OFS_TABLE_PTR_UPPER 4'h5
`define RCS_OFS_TABLE_PTR_HIGH 4'h6
`define RCS_OFS_TABLE_PTR_LOW 4'h7
`define RCS_OFS_TABLE_LATCH 4'h8
`define RCS_OFS_PC_LATCH_UPPER 4'h9
`define RCS_OFS_PC_LATCH_HIGH 4'ha
`define RCS_OFS_IRQ_CTRL_SECOND 4'hb
`define RCS_OFS_IRQ_CTRL_THIRD 4'hc

// Reset control register bit positions
`define RCS_BIT_SOFT_BOR_EN 6
`define RCS_BIT_SOFT_RESET_N 4
`define RCS_BIT_WDOG_EXPIRED_N 3
`define RCS_BIT_SLEEP_ENTERED_N 2
`define RCS_BIT_POWER_ON_N 1
`define RCS_BIT_BROWNOUT_N 0

// Stack pointer register bit positions
`define RCS_BIT_STACK_FULL 7
`define RCS_BIT_STACK_UNDERFLOW 6

// Reset values, write masks and soft brown-out configuration code
`define RCS_RST_IRQ_CTRL_SECOND 8'hf5
`define RCS_RST_IRQ_CTRL_THIRD 8'hc0
`define RCS_MASK_IRQ_CTRL_SECOND 8'hf5
`define RCS_MASK_IRQ_CTRL_THIRD 8'hdb
`define RCS_BOR_CFG_SOFT 2'b01

// Program counter targets
`define RCS_PC_RESET 21'h000000
`define RCS_PC_VEC_HIGH 21'h000008
`define RCS_PC_VEC_LOW 21'h000018
`define RCS_PC_STEP 21'h000002

// Power modes
`define RCS_MODE_FULL 2'b00
`define RCS_MODE_PM_RUN 2'b01
`define RCS_MODE_IDLE 2'b10
`define RCS_MODE_SLEEP 2'b11

`endif

// ### rcs_reset_status.v
// Purpose: Reset cause flags, stack status and core register reset states.
// Assumes: rst_b low is the power-on reset; other causes arrive as pulses.
// Notes: Register port answers one cycle after the read strobe.
// Behaviour
// - Power-on: start 0000h, flags to power-on pattern
// - Reset instruction restarts, clears soft-reset flag only
// - Brown-out restarts, sets three flags, clears brown-out
// - Pin reset in run mode sets watchdog flag
// - Pin reset in idle/sleep: watchdog set, sleep cleared
// - Watchdog timeout running resets, clears watchdog flag
// - Pin reset at full power changes no flag
// - Stack full with enable resets, sets full
// - Underflow with enable resets, sets underflow flag
// - Underflow without enable: flag set, no reset
// - Watchdog wake: continue PC+2, clear two flags
// - Interrupt wake clears sleep flag, PC+2 or vector
// - Soft brown-out enable reset value by configuration
// - Undefined registers keep contents across non-power resets
// - Watchdog wake keeps most register contents
// - Vectored wake pushes PC, advances stack pointer
// - Stack pointer reset values per reset type
// - Table pointers and latches clear on resets
// - Interrupt control registers load reset patterns
// - Wake-causing interrupt flag bits change on wake
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "rcs_defines.vh"
module rcs_reset_status #(
    parameter PC_W = 21
) (
    input wire clk_sys,
    input wire rst_b,
    input wire external_reset_pin_n,
    input wire brownout_evt,
    input wire reset_instr_evt,
    input wire watchdog_timer_evt,
    input wire stack_full_evt,
    input wire stack_underflow_evt,
    input wire irq_wake_evt,
    input wire irq_wake_high,
    input wire [7:0] wake_flags_second,
    input wire [7:0] wake_flags_third,
    input wire [1:0] power_mode,
    input wire [1:0] brownout_config_bits,
    input wire stack_overrun_reset_enable,
    input wire high_prio_global_irq_enable,
    input wire low_prio_global_irq_enable,
    input wire [PC_W-1:0] pc_current,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg core_restart,
    output reg pc_load,
    output reg [PC_W-1:0] pc_load_addr,
    output reg stack_error
);

// Reset control register fields
reg soft_brownout_enable_q;
reg soft_reset_flag_n_q;
reg watchdog_expired_flag_n_q;
reg sleep_entered_flag_n_q;
reg power_on_flag_n_q;
reg brownout_flag_n_q;
// Stack pointer register fields
reg stack_full_flag_q;
reg stack_underflow_flag_q;
reg [4:0] stack_ptr_q;
// Stack top, table pointer, latch and interrupt control registers
reg [4:0] stack_top_upper_q;
reg [7:0] stack_top_high_q;
reg [7:0] stack_top_low_q;
reg [5:0] table_pointer_upper_q;
reg [7:0] table_ptr_high_q;
reg [7:0] table_ptr_low_q;
reg [7:0] table_latch_q;
reg [4:0] pc_latch_upper_q;
reg [7:0] pc_latch_high_q;
reg [7:0] irq_control_second_q;
reg [7:0] irq_control_third_q;
// Pin edge tracking
reg pin_prev_q;

wire pin_level;
wire pin_assert;
wire in_idle_sleep;
wire in_pm_run;
wire in_full;
wire soft_bor_cfg;
wire any_gie;
wire [PC_W-1:0] pc_next;
wire [PC_W-1:0] vector_addr;
wire [23:0] pc_wide;

// Decoded event classes, one cause handled per cycle
wire ev_bor;
wire ev_pin;
wire ev_wdt_reset;
wire ev_wdt_wake;
wire ev_instr;
wire ev_full_rst;
wire ev_unf_rst;
wire ev_unf_err;
wire ev_irq_wake;
wire ev_irq_vector;
wire any_reset;
wire any_wake;
wire sw_wr_reset_control_register;
wire sw_wr_sp;

// External pin passes the three-stage filter before use
rcs_sync3 #(
    .RESET_LEVEL(1'b1)
) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in(external_reset_pin_n),
    .level_q(pin_level)
);

// Mode and configuration decode
assign in_full = (power_mode == `RCS_MODE_FULL);
assign in_pm_run = (power_mode == `RCS_MODE_PM_RUN);
assign in_idle_sleep = (power_mode == `RCS_MODE_IDLE) || (power_mode == `RCS_MODE_SLEEP);
assign soft_bor_cfg = (brownout_config_bits == `RCS_BOR_CFG_SOFT);
assign any_gie = high_prio_global_irq_enable || low_prio_global_irq_enable;
assign pin_assert = pin_prev_q && !pin_level;
assign pc_next = pc_current + `RCS_PC_STEP;
assign vector_addr = irq_wake_high ? `RCS_PC_VEC_HIGH : `RCS_PC_VEC_LOW;
assign pc_wide = {{(24-PC_W){1'b0}}, pc_current};

// Priority: brown-out, pin, watchdog, instruction, stack; interrupt wake last
assign ev_bor = brownout_evt;
assign ev_pin = !ev_bor && pin_assert;
assign ev_wdt_reset = !ev_bor && !ev_pin && watchdog_timer_evt && !in_idle_sleep;
assign ev_wdt_wake = !ev_bor && !ev_pin && watchdog_timer_evt && in_idle_sleep;
assign ev_instr = !ev_bor && !ev_pin && !watchdog_timer_evt && reset_instr_evt;
assign ev_full_rst = !ev_bor && !ev_pin && !watchdog_timer_evt && !reset_instr_evt &&
                     stack_full_evt && stack_overrun_reset_enable;
assign ev_unf_rst = !ev_bor && !ev_pin && !watchdog_timer_evt && !reset_instr_evt &&
                    !stack_full_evt && stack_underflow_evt && stack_overrun_reset_enable;
assign ev_unf_err = !ev_bor && !ev_pin && !watchdog_timer_evt && !reset_instr_evt &&
                    stack_underflow_evt && !stack_overrun_reset_enable;
assign ev_irq_wake = !ev_bor && !ev_pin && !watchdog_timer_evt && !reset_instr_evt &&
                     !stack_full_evt && !stack_underflow_evt && irq_wake_evt && !in_full;
assign ev_irq_vector = ev_irq_wake && any_gie;
assign any_reset = ev_bor || ev_pin || ev_wdt_reset || ev_instr || ev_full_rst || ev_unf_rst;
assign any_wake = ev_wdt_wake || ev_irq_wake;
assign sw_wr_reset_control_register = reg_wr && (reg_addr == `RCS_OFS_RESET_CONTROL);
assign sw_wr_sp = reg_wr && (reg_addr == `RCS_OFS_STACK_POINTER);

// Pin history for assertion edge
always @(posedge clk_sys) begin
    if (!rst_b) begin
        pin_prev_q <= 1'b1;
    end else begin
        pin_prev_q <= pin_level;
    end
end

// Restart and program counter steering
always @(posedge clk_sys) begin
    if (!rst_b) begin
        core_restart <= 1'b1;
        pc_load <= 1'b1;
        pc_load_addr <= `RCS_PC_RESET;
        stack_error <= 1'b0;
    end else begin
        core_restart <= any_reset;
        pc_load <= any_reset || any_wake;
        stack_error <= ev_unf_err;
        if (any_reset) begin
            pc_load_addr <= `RCS_PC_RESET;
        end else if (ev_irq_vector) begin
            pc_load_addr <= vector_addr;
        end else if (any_wake) begin
            pc_load_addr <= pc_next;
        end
    end
end

// Reset cause flags; hardware events win over a software write
always @(posedge clk_sys) begin
    if (!rst_b) begin
        soft_brownout_enable_q <= 1'b1;
        soft_reset_flag_n_q <= 1'b1;
        watchdog_expired_flag_n_q <= 1'b1;
        sleep_entered_flag_n_q <= 1'b1;
        power_on_flag_n_q <= 1'b0;
        brownout_flag_n_q <= 1'b0;
    end else begin
        if (sw_wr_reset_control_register) begin
            soft_brownout_enable_q <= reg_wdata[`RCS_BIT_SOFT_BOR_EN] && soft_bor_cfg;
            soft_reset_flag_n_q <= reg_wdata[`RCS_BIT_SOFT_RESET_N];
            power_on_flag_n_q <= reg_wdata[`RCS_BIT_POWER_ON_N];
            brownout_flag_n_q <= reg_wdata[`RCS_BIT_BROWNOUT_N];
        end
        // Outside the soft configuration the enable is held at zero
        if (!soft_bor_cfg) begin
            soft_brownout_enable_q <= 1'b0;
        end
        if (ev_bor) begin
            soft_reset_flag_n_q <= 1'b1;
            watchdog_expired_flag_n_q <= 1'b1;
            sleep_entered_flag_n_q <= 1'b1;
            brownout_flag_n_q <= 1'b0;
        end
        if (ev_instr) begin
            soft_reset_flag_n_q <= 1'b0;
        end
        if (ev_pin && in_pm_run) begin
            watchdog_expired_flag_n_q <= 1'b1;
        end
        if (ev_pin && in_idle_sleep) begin
            watchdog_expired_flag_n_q <= 1'b1;
            sleep_entered_flag_n_q <= 1'b0;
        end
        // A pin reset at full power leaves every flag alone
        if (ev_wdt_reset) begin
            watchdog_expired_flag_n_q <= 1'b0;
        end
        if (ev_wdt_wake) begin
            watchdog_expired_flag_n_q <= 1'b0;
            sleep_entered_flag_n_q <= 1'b0;
        end
        if (ev_irq_wake) begin
            sleep_entered_flag_n_q <= 1'b0;
        end
    end
end

// Stack pointer, stack flags and top of stack
always @(posedge clk_sys) begin
    if (!rst_b) begin
        stack_full_flag_q <= 1'b0;
        stack_underflow_flag_q <= 1'b0;
        stack_ptr_q <= 5'h00;
        stack_top_upper_q <= 5'h00;
        stack_top_high_q <= 8'h00;
        stack_top_low_q <= 8'h00;
    end else begin
        if (sw_wr_sp) begin
            stack_full_flag_q <= stack_full_flag_q && reg_wdata[`RCS_BIT_STACK_FULL];
            stack_underflow_flag_q <= stack_underflow_flag_q &&
                                      reg_wdata[`RCS_BIT_STACK_UNDERFLOW];
            stack_ptr_q <= reg_wdata[4:0];
        end
        // Every reset, brown-out too, clears the pointer and stack top, never the flags
        if (any_reset) begin
            stack_ptr_q <= 5'h00;
        end else if (ev_irq_vector) begin
            stack_ptr_q <= stack_ptr_q + 5'h01;
        end
        if (ev_full_rst) begin
            stack_full_flag_q <= 1'b1;
        end
        if (ev_unf_rst || ev_unf_err) begin
            stack_underflow_flag_q <= 1'b1;
        end
        if (any_reset) begin
            stack_top_upper_q <= 5'h00;
            stack_top_high_q <= 8'h00;
            stack_top_low_q <= 8'h00;
        end else if (ev_irq_vector) begin
            stack_top_upper_q <= pc_wide[20:16];
            stack_top_high_q <= pc_wide[15:8];
            stack_top_low_q <= pc_wide[7:0];
        end
    end
end

// Table pointers, latches and program counter latches
always @(posedge clk_sys) begin
    if (!rst_b) begin
        table_pointer_upper_q <= 6'h00;
        table_ptr_high_q <= 8'h00;
        table_ptr_low_q <= 8'h00;
        table_latch_q <= 8'h00;
        pc_latch_upper_q <= 5'h00;
        pc_latch_high_q <= 8'h00;
    end else if (any_reset) begin
        table_pointer_upper_q <= 6'h00;
        table_ptr_high_q <= 8'h00;
        table_ptr_low_q <= 8'h00;
        table_latch_q <= 8'h00;
        pc_latch_upper_q <= 5'h00;
        pc_latch_high_q <= 8'h00;
    end else if (reg_wr) begin
        // Wakes fall through here, so contents hold across them
        case (reg_addr)
            `RCS_OFS_TABLE_PTR_UPPER: table_pointer_upper_q <= reg_wdata[5:0];
            `RCS_OFS_TABLE_PTR_HIGH: table_ptr_high_q <= reg_wdata;
            `RCS_OFS_TABLE_PTR_LOW: table_ptr_low_q <= reg_wdata;
            `RCS_OFS_TABLE_LATCH: table_latch_q <= reg_wdata;
            `RCS_OFS_PC_LATCH_UPPER: pc_latch_upper_q <= reg_wdata[4:0];
            `RCS_OFS_PC_LATCH_HIGH: pc_latch_high_q <= reg_wdata;
            default: begin
            end
        endcase
    end
end

// Interrupt control registers; wake sources set their own flags
always @(posedge clk_sys) begin
    if (!rst_b) begin
        irq_control_second_q <= `RCS_RST_IRQ_CTRL_SECOND;
        irq_control_third_q <= `RCS_RST_IRQ_CTRL_THIRD;
    end else if (any_reset) begin
        irq_control_second_q <= `RCS_RST_IRQ_CTRL_SECOND;
        irq_control_third_q <= `RCS_RST_IRQ_CTRL_THIRD;
    end else begin
        if (reg_wr && (reg_addr == `RCS_OFS_IRQ_CTRL_SECOND)) begin
            irq_control_second_q <= reg_wdata & `RCS_MASK_IRQ_CTRL_SECOND;
        end
        if (reg_wr && (reg_addr == `RCS_OFS_IRQ_CTRL_THIRD)) begin
            irq_control_third_q <= reg_wdata & `RCS_MASK_IRQ_CTRL_THIRD;
        end
        // OR in so a same-cycle software write cannot drop a wake flag
        if (ev_irq_wake) begin
            irq_control_second_q <= ((reg_wr && (reg_addr == `RCS_OFS_IRQ_CTRL_SECOND)) ?
                reg_wdata : irq_control_second_q) &
                `RCS_MASK_IRQ_CTRL_SECOND | (wake_flags_second &
                `RCS_MASK_IRQ_CTRL_SECOND);
            irq_control_third_q <= ((reg_wr && (reg_addr == `RCS_OFS_IRQ_CTRL_THIRD)) ?
                reg_wdata : irq_control_third_q) &
                `RCS_MASK_IRQ_CTRL_THIRD | (wake_flags_third &
                `RCS_MASK_IRQ_CTRL_THIRD);
        end
    end
end

// Read data, one cycle after the strobe; unmapped reads give zero
always @(posedge clk_sys) begin
    if (!rst_b) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd) begin
        case (reg_addr)
            `RCS_OFS_RESET_CONTROL: begin
                reg_rdata <= {1'b0, soft_brownout_enable_q, 1'b0, soft_reset_flag_n_q,
                              watchdog_expired_flag_n_q, sleep_entered_flag_n_q,
                              power_on_flag_n_q, brownout_flag_n_q};
            end
            `RCS_OFS_STACK_POINTER: reg_rdata <= {stack_full_flag_q, stack_underflow_flag_q,
                                                  1'b0, stack_ptr_q};
            `RCS_OFS_STACK_TOP_UPPER: reg_rdata <= {3'b000, stack_top_upper_q};
            `RCS_OFS_STACK_TOP_HIGH: reg_rdata <= stack_top_high_q;
            `RCS_OFS_STACK_TOP_LOW: reg_rdata <= stack_top_low_q;
            `RCS_OFS_TABLE_PTR_UPPER: reg_rdata <= {2'b00, table_pointer_upper_q};
            `RCS_OFS_TABLE_PTR_HIGH: reg_rdata <= table_ptr_high_q;
            `RCS_OFS_TABLE_PTR_LOW: reg_rdata <= table_ptr_low_q;
            `RCS_OFS_TABLE_LATCH: reg_rdata <= table_latch_q;
            `RCS_OFS_PC_LATCH_UPPER: reg_rdata <= {3'b000, pc_latch_upper_q};
            `RCS_OFS_PC_LATCH_HIGH: reg_rdata <= pc_latch_high_q;
            `RCS_OFS_IRQ_CTRL_SECOND: reg_rdata <= irq_control_second_q;
            `RCS_OFS_IRQ_CTRL_THIRD: reg_rdata <= irq_control_third_q;
            default: reg_rdata <= 8'h00;
        endcase
    end else begin
        reg_rdata <= 8'h00;
    end
end

// All held registers here have defined reset values; none is left undefined

endmodule
`default_nettype wire

// ### rcs_reset_status_properties.sv
// Purpose: Concurrent checks on the reset cause and status outputs.
// Assumes: One clock domain; rst_b low is the power-on reset.
// Notes: The pin synchroniser hides its events, so wake and error checks
// only count once the pin has been high long enough to rule a pin reset out.
`timescale 1ns/100ps
`default_nettype none
`include "rcs_defines.vh"
module rcs_reset_status_properties #(
    parameter PC_W = 21
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic external_reset_pin_n,
    input wire logic brownout_evt,
    input wire logic reset_instr_evt,
    input wire logic watchdog_timer_evt,
    input wire logic stack_full_evt,
    input wire logic stack_underflow_evt,
    input wire logic irq_wake_evt,
    input wire logic irq_wake_high,
    input wire logic [1:0] power_mode,
    input wire logic stack_overrun_reset_enable,
    input wire logic high_prio_global_irq_enable,
    input wire logic low_prio_global_irq_enable,
    input wire logic [PC_W-1:0] pc_current,
    input wire logic core_restart,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_load_addr,
    input wire logic stack_error
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // Higher-priority causes absent; pin handled by the sequence below
    wire hi_calm = !brownout_evt && !watchdog_timer_evt && !reset_instr_evt;
    wire all_calm = hi_calm && !stack_full_evt && !stack_underflow_evt;
    wire gie_any = high_prio_global_irq_enable || low_prio_global_irq_enable;
    wire unf_only = stack_underflow_evt && hi_calm && !stack_full_evt;

    // Long enough for the pin filter to have no event in flight
    sequence pin_quiet;
        external_reset_pin_n [*8];
    endsequence
    sequence restart_zero;
        core_restart && pc_load && pc_load_addr == `RCS_PC_RESET;
    endsequence

    bor_restart_a: assert property (brownout_evt |=> restart_zero)
        else $error("brown-out did not restart at zero");
    instr_restart_a: assert property (reset_instr_evt |=> restart_zero)
        else $error("reset instruction did not restart at zero");
    wdt_run_a: assert property (watchdog_timer_evt && !power_mode[1] |=> restart_zero)
        else $error("watchdog in run did not restart");
    wdt_wake_a: assert property (
        pin_quiet ##0 (watchdog_timer_evt && power_mode[1] && !brownout_evt)
        |=> pc_load && !core_restart && pc_load_addr == $past(pc_current) + `RCS_PC_STEP)
        else $error("watchdog wake did not resume at pc plus two");
    stk_full_a: assert property (stack_full_evt && stack_overrun_reset_enable && hi_calm
        |=> restart_zero) else $error("stack full did not restart");
    stk_unf_a: assert property (unf_only && stack_overrun_reset_enable |=> restart_zero)
        else $error("stack underflow did not restart");
    unf_error_a: assert property (
        pin_quiet ##0 (unf_only && !stack_overrun_reset_enable)
        |=> stack_error && !core_restart && !pc_load)
        else $error("underflow without enable not reported as error");
    err_source_a: assert property ($rose(stack_error)
        |-> $past(stack_underflow_evt) && !$past(stack_overrun_reset_enable))
        else $error("stack error without an unenabled underflow");
    irq_vector_a: assert property (
        pin_quiet ##0 (irq_wake_evt && power_mode != 2'h0 && all_calm && gie_any)
        |=> pc_load && !core_restart
        && pc_load_addr == ($past(irq_wake_high) ? `RCS_PC_VEC_HIGH : `RCS_PC_VEC_LOW))
        else $error("vectored wake loaded wrong address");
    irq_ignored_a: assert property (
        pin_quiet ##0 (irq_wake_evt && power_mode == 2'h0 && all_calm)
        |=> !pc_load && !core_restart)
        else $error("interrupt wake acted at full power");
endmodule

bind rcs_reset_status rcs_reset_status_properties #(.PC_W(PC_W)) chk_u (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .external_reset_pin_n(external_reset_pin_n),
    .brownout_evt(brownout_evt),
    .reset_instr_evt(reset_instr_evt),
    .watchdog_timer_evt(watchdog_timer_evt),
    .stack_full_evt(stack_full_evt),
    .stack_underflow_evt(stack_underflow_evt),
    .irq_wake_evt(irq_wake_evt),
    .irq_wake_high(irq_wake_high),
    .power_mode(power_mode),
    .stack_overrun_reset_enable(stack_overrun_reset_enable),
    .high_prio_global_irq_enable(high_prio_global_irq_enable),
    .low_prio_global_irq_enable(low_prio_global_irq_enable),
    .pc_current(pc_current),
    .core_restart(core_restart),
    .pc_load(pc_load),
    .pc_load_addr(pc_load_addr),
    .stack_error(stack_error)
);
`default_nettype wire

// ### rcs_sync3.v
// Purpose: Three-stage synchroniser with agreement filter for a pin input.
// Assumes: Input is asynchronous to clk_sys.
// Notes: Output changes only when the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none
module rcs_sync3 #(
    parameter RESET_LEVEL = 1'b1
) (
    input wire clk_sys,
    input wire rst_b,
    input wire async_in,
    output reg level_q
);

reg s1_q;
reg s2_q;
reg s3_q;

// First stage feeds only the second; filter looks at stages two and three
always @(posedge clk_sys) begin
    if (!rst_b) begin
        s1_q <= RESET_LEVEL;
        s2_q <= RESET_LEVEL;
        s3_q <= RESET_LEVEL;
        level_q <= RESET_LEVEL;
    end else begin
        s1_q <= async_in;
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end
end

endmodule
`default_nettype wire

// ### test_reset_cause_status_logic.sv
// Purpose: Self-checking bench for the reset cause and status logic.
// Assumes: Read data stand only in the cycle after the read strobe.
// Notes: Pin resets are awaited under a bounded count of 20 cycles; the filter delay itself is fixed.
`timescale 1ns/100ps
`default_nettype none
`include "rcs_defines.vh"
module test_reset_cause_status_logic;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic pin_n = 1'b1;
    logic [5:0] ev = 6'h00; // Bits: bor, instr, wdt, full, underflow, irq
    logic irq_high = 1'b0;
    logic [7:0] wf2 = 8'h00;
    logic [7:0] wf3 = 8'h00;
    logic [1:0] mode = 2'h0;
    logic [1:0] cfg = 2'h1;
    logic stk_en = 1'b1;
    logic gie_h = 1'b0;
    logic gie_l = 1'b0;
    logic [20:0] pc_now = 21'h001234;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [7:0] reg_rdata;
    wire core_restart;
    wire pc_load;
    wire stack_error;
    wire [20:0] pc_load_addr;
    int err_count = 0;
    int checks_done = 0;
    // Expected contents of offsets 0..d after power-on in soft brown-out config
    logic [7:0] por_tab [14] = '{8'h5c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'hf5, 8'hc0, 8'h00};

    rcs_reset_status dut_u (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .external_reset_pin_n(pin_n),
        .brownout_evt(ev[0]),
        .reset_instr_evt(ev[1]),
        .watchdog_timer_evt(ev[2]),
        .stack_full_evt(ev[3]),
        .stack_underflow_evt(ev[4]),
        .irq_wake_evt(ev[5]),
        .irq_wake_high(irq_high),
        .wake_flags_second(wf2),
        .wake_flags_third(wf3),
        .power_mode(mode),
        .brownout_config_bits(cfg),
        .stack_overrun_reset_enable(stk_en),
        .high_prio_global_irq_enable(gie_h),
        .low_prio_global_irq_enable(gie_l),
        .pc_current(pc_now),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .core_restart(core_restart),
        .pc_load(pc_load),
        .pc_load_addr(pc_load_addr),
        .stack_error(stack_error)
    );

    // 40 MHz system clock
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [20:0] got, input logic [20:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic note(input string s);
        $display("test %s done", s);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Power-on reset; outputs are checked while reset is still held
    task automatic por(input logic [1:0] c);
        @(posedge clk_sys);
        cfg <= c;
        rst_b <= 1'b0;
        repeat (10) @(posedge clk_sys);
        #1 chk_out({core_restart, pc_load}, 21'h3);
        chk_out(pc_load_addr, `RCS_PC_RESET);
        @(posedge clk_sys);
        rst_b <= 1'b1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk_reg(reg_rdata, exp);
    endtask

    // One-cycle event; rls is {core_restart, pc_load, stack_error} a cycle later
    task automatic fire(input logic [1:0] m, input logic [5:0] e, input logic [2:0] rls,
        input logic [20:0] a);
        @(posedge clk_sys);
        mode <= m;
        ev <= e;
        @(posedge clk_sys);
        ev <= 6'h00;
        #1 chk_out({core_restart, pc_load, stack_error}, rls);
        if (rls[1]) begin
            chk_out(pc_load_addr, a);
        end
    endtask

    // Pin held low until the filtered event restarts the core
    task automatic pin_rst(input logic [1:0] m);
        int n;
        @(posedge clk_sys);
        mode <= m;
        pin_n <= 1'b0;
        n = 0;
        while (core_restart !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk_out(core_restart, 21'h1);
        chk_out(pc_load_addr, `RCS_PC_RESET);
        @(posedge clk_sys);
        pin_n <= 1'b1;
        repeat (10) @(posedge clk_sys);
    endtask

    // Main sequence; register values track the flag history step by step
    initial begin
        por(2'h1);
        for (int i = 0; i < 14; i++) begin
            rd(i[3:0], por_tab[i]);
        end
        wr(`RCS_OFS_RESET_CONTROL, 8'h53);
        rd(`RCS_OFS_RESET_CONTROL, 8'h5f);
        note("power_on");
        fire(2'h0, 6'h02, 3'b110, 21'h0);
        rd(4'h0, 8'h4f);
        wr(`RCS_OFS_TABLE_PTR_UPPER, 8'h2a);
        fire(2'h3, 6'h04, 3'b010, 21'h001236);
        rd(4'h0, 8'h43);
        rd(`RCS_OFS_TABLE_PTR_UPPER, 8'h2a);
        pin_rst(2'h2);
        rd(4'h0, 8'h4b);
        rd(`RCS_OFS_TABLE_PTR_UPPER, 8'h00);
        fire(2'h0, 6'h01, 3'b110, 21'h0);
        rd(4'h0, 8'h5e);
        fire(2'h0, 6'h04, 3'b110, 21'h0);
        rd(4'h0, 8'h56);
        pin_rst(2'h0);
        rd(4'h0, 8'h56);
        pin_rst(2'h1);
        rd(4'h0, 8'h5e);
        note("resets");
        fire(2'h0, 6'h08, 3'b110, 21'h0);
        rd(`RCS_OFS_STACK_POINTER, 8'h80);
        fire(2'h0, 6'h10, 3'b110, 21'h0);
        rd(`RCS_OFS_STACK_POINTER, 8'hc0);
        wr(`RCS_OFS_STACK_POINTER, 8'h00);
        stk_en <= 1'b0;
        fire(2'h0, 6'h10, 3'b001, 21'h0);
        rd(`RCS_OFS_STACK_POINTER, 8'h40);
        note("stack");
        @(posedge clk_sys);
        gie_h <= 1'b1;
        irq_high <= 1'b1;
        wf3 <= 8'h01;
        fire(2'h3, 6'h20, 3'b010, `RCS_PC_VEC_HIGH);
        rd(`RCS_OFS_STACK_POINTER, 8'h41);
        rd(`RCS_OFS_STACK_TOP_UPPER, 8'h00);
        rd(`RCS_OFS_STACK_TOP_HIGH, 8'h12);
        rd(`RCS_OFS_STACK_TOP_LOW, 8'h34);
        rd(`RCS_OFS_IRQ_CTRL_THIRD, 8'hc1);
        rd(4'h0, 8'h5a);
        @(posedge clk_sys);
        gie_h <= 1'b0;
        gie_l <= 1'b1;
        irq_high <= 1'b0;
        fire(2'h2, 6'h20, 3'b010, `RCS_PC_VEC_LOW);
        rd(`RCS_OFS_STACK_POINTER, 8'h42);
        @(posedge clk_sys);
        gie_l <= 1'b0;
        fire(2'h1, 6'h20, 3'b010, 21'h001236);
        rd(`RCS_OFS_STACK_POINTER, 8'h42);
        fire(2'h0, 6'h20, 3'b000, 21'h0);
        note("wake");
        por(2'h2);
        rd(4'h0, 8'h1c);
        rd(`RCS_OFS_IRQ_CTRL_THIRD, 8'hc0);
        rd(4'hd, 8'h00);
        note("config");
        stop_test;
    end

    // The whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk_sys);
        err_count++;
        stop_test;
    end
endmodule
`default_nettype wire
